// [osc_switch_defines.svh]
// Purpose: constants for the internal oscillator clock switch
// Assumes: 40 MHz ref_clk, Avalon-MM register slave with word addressing in bytes
// Notes: offsets are byte addresses, fields hold bit positions
`ifndef OSC_SWITCH_DEFINES_SVH
`define OSC_SWITCH_DEFINES_SVH
`define OFS_CTRL 4'h0
`define OFS_STAT 4'h4
`define OFS_CFG 4'h8
`define CTRL_SCS_LSB 0
`define CTRL_INTERNAL_FREQ_SELECT_LSB 3
`define CTRL_SPLL_BIT 7
`define CTRL_RESET 8'h38
`define SRC_INTERNAL_OSC_SOURCE 3'h4
`define SCS_CONFIG 2'h0
`define INTERNAL_FREQ_SELECT_8MHZ_HF 4'he
`define STARTUP_NS 2000
`define STARTUP_CYC ((`STARTUP_NS * 40 + 999) / 1000)
`define STAT_HF_BIT 0
`define STAT_MF_BIT 1
`define STAT_LF_BIT 2
`define STAT_PLL_BIT 3
`define STAT_BUSY_BIT 4
`endif

// [osc_switch_pkg.sv]
// Purpose: types for the internal oscillator clock switch
// Assumes: nothing beyond the defines header
// Notes: oscillator index order is hf, mf, lf
package osc_switch_pkg;
   typedef enum logic [1:0] {
      osc_hf_type_e = 2'b00,
      osc_mf_type_e = 2'b01,
      osc_lf_type_e = 2'b10
   } osc_id_type;
   typedef struct packed {
      logic [3:0] address;
      logic read;
      logic write;
      logic [31:0] writedata;
   } bus_req_type;
   typedef struct packed {
      logic [31:0] readdata;
      logic waitrequest;
   } bus_rsp_type;
endpackage

// [edge_handover.sv]
// Purpose: glitch-free handover between two oscillator clocks sampled on ref_clk
// Assumes: old and new clocks are slow compared to ref_clk and synchronous levels
// Notes: raises done once the new clock has taken over the output
module edge_handover (
   input wire logic ref_clk, // block clock
   input wire logic rstn, // synchronous reset, active low
   input wire logic start, // one-cycle pulse, begin a handover
   input wire logic old_clk, // level of current clock
   input wire logic new_clk, // level of new clock
   output logic hold_low, // output clock forced low
   output logic done // one-cycle pulse, new clock active
);
   typedef enum logic [1:0] {
      h_idle = 2'b00,
      h_wait_fall = 2'b01,
      h_wait_rise = 2'b10
   } hstate_type;
   hstate_type st_r;
   logic old_d_r, new_d_r;
   // edge history for falling and rising detection
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         old_d_r <= 1'b0;
         new_d_r <= 1'b0;
      end else begin
         old_d_r <= old_clk;
         new_d_r <= new_clk;
      end
   end
   // wait for old falling edge, hold low, wait for new rising edge
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         st_r <= h_idle;
         hold_low <= 1'b0;
         done <= 1'b0;
      end else begin
         done <= 1'b0;
         case (st_r)
            h_idle: begin
               if (start) st_r <= h_wait_fall;
            end
            h_wait_fall: begin
               if (old_d_r && !old_clk) begin
                  hold_low <= 1'b1;
                  st_r <= h_wait_rise;
               end
            end
            h_wait_rise: begin
               if (!new_d_r && new_clk) begin
                  hold_low <= 1'b0;
                  done <= 1'b1;
                  st_r <= h_idle;
               end
            end
            default: st_r <= h_idle;
         endcase
      end
   end
endmodule

// [osc_switch.sv]
// Purpose: internal oscillator frequency and system clock source control
// Assumes: config straps steady after reset, oscillator clocks sampled on ref_clk
// Notes: registers over Avalon-MM, one wait state on every access
// What this block does
// - config pattern 100 picks internal oscillator
// - select 00 follows the config source
// - frequency pattern 1110 selects 8 MHz high osc
// - pll on by soft or config enable
// - config pll turns pll on unless select 1x, no 8 MHz
// - select 1x keeps pll off internal osc
// - stopped new oscillator gets start-up delay
// - old falling edge, hold low, new rising
// - status shows active oscillators after switch
// - same-source switch skips start-up delay
//
// Added by the designer: register access over Avalon-MM and the placing of the registers.
`include "osc_switch_defines.svh"
module osc_switch #(
   parameter int STARTUP_CYCLES = `STARTUP_CYC // start-up delay in ref_clk cycles
) (
   input wire logic ref_clk, // 40 MHz block clock
   input wire logic rstn, // synchronous reset, active low
   input wire osc_switch_pkg::bus_req_type bus_req, // avalon request
   output osc_switch_pkg::bus_rsp_type bus_rsp, // avalon answer
   input wire logic [2:0] clock_source_config, // configuration clock source field
   input wire logic config_pll_enable, // configuration pll enable bit
   input wire logic hf_clk, // high frequency internal oscillator
   input wire logic mf_clk, // mid frequency internal oscillator
   input wire logic lf_clk, // low frequency internal oscillator
   output logic [2:0] osc_enable, // oscillator run enables, hf mf lf
   output logic pll_enable, // 4x pll enable
   output logic use_internal_osc, // system clock from internal osc
   output logic [3:0] active_freq_select, // frequency code now driving the system
   output logic sys_clk_hold_low, // system clock held low during handover
   output logic [1:0] active_osc // oscillator now driving the system
);
   import osc_switch_pkg::*;
   typedef enum logic [1:0] {
      s_idle = 2'b00,
      s_startup = 2'b01,
      s_handover = 2'b10,
      s_status = 2'b11
   } sw_state_type;
   sw_state_type st_r;
   logic [1:0] system_clock_select_r;
   logic [3:0] internal_freq_select_r;
   logic soft_pll_enable_r;
   logic [2:0] cfg_src_r;
   logic cfg_pll_r;
   logic [3:0] pend_freq_r;
   logic [1:0] pend_osc_r;
   logic [15:0] cnt_r;
   logic [2:0] stat_osc_r;
   logic ack_r;
   logic hs_start_r;
   logic hs_hold, hs_done;
   logic [3:0] wr_freq;
   logic [1:0] tgt_osc;
   logic [2:0] clk_vec;
   logic old_lvl, new_lvl;
   logic [7:0] ctrl_rd;
   logic [7:0] stat_rd;
   // frequency code to oscillator: 1111..1100 hf, 0001 and 0000 lf, others mf
   function automatic logic [1:0] osc_of(input logic [3:0] f);
      if (f[3:2] == 2'b11 || f == 4'hd) osc_of = osc_hf_type_e;
      else if (f == 4'h0 || f == 4'h1) osc_of = osc_lf_type_e;
      else osc_of = osc_mf_type_e;
   endfunction
   // strap capture after reset release
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         cfg_src_r <= 3'h0;
         cfg_pll_r <= 1'b0;
      end else begin
         cfg_src_r <= clock_source_config;
         cfg_pll_r <= config_pll_enable;
      end
   end
   // config pll forbids the plain 8 MHz code, remap to the pll-backed code
   always_comb begin
      wr_freq = bus_req.writedata[`CTRL_INTERNAL_FREQ_SELECT_LSB +: 4];
      if (cfg_pll_r && wr_freq == `INTERNAL_FREQ_SELECT_8MHZ_HF) wr_freq = 4'hf;
   end
   // avalon: one wait state, waitrequest drops the cycle after request
   always_ff @(posedge ref_clk) begin
      if (!rstn) ack_r <= 1'b0;
      else ack_r <= (bus_req.read || bus_req.write) && !ack_r;
   end
   // control register writes
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         system_clock_select_r <= 2'((`CTRL_RESET >> `CTRL_SCS_LSB) & 8'h03);
         internal_freq_select_r <= 4'h7;
         soft_pll_enable_r <= 1'b0;
      end else if (bus_req.write && ack_r && bus_req.address == `OFS_CTRL) begin
         system_clock_select_r <= bus_req.writedata[`CTRL_SCS_LSB +: 2];
         internal_freq_select_r <= wr_freq;
         soft_pll_enable_r <= bus_req.writedata[`CTRL_SPLL_BIT];
      end
   end
   assign tgt_osc = osc_of(internal_freq_select_r);
   assign clk_vec = {lf_clk, mf_clk, hf_clk};
   assign old_lvl = clk_vec[active_osc];
   assign new_lvl = clk_vec[pend_osc_r];
   // switch sequencer
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         st_r <= s_idle;
         pend_freq_r <= 4'h7;
         pend_osc_r <= osc_mf_type_e;
         cnt_r <= 16'h0;
         hs_start_r <= 1'b0;
      end else begin
         hs_start_r <= 1'b0;
         case (st_r)
            s_idle: begin
               if (internal_freq_select_r != active_freq_select) begin
                  pend_freq_r <= internal_freq_select_r;
                  pend_osc_r <= tgt_osc;
                  if (tgt_osc == active_osc) begin
                     st_r <= s_status;
                  end else if (!stat_osc_r[tgt_osc]) begin
                     cnt_r <= 16'(STARTUP_CYCLES);
                     st_r <= s_startup;
                  end else begin
                     hs_start_r <= 1'b1;
                     st_r <= s_handover;
                  end
               end
            end
            s_startup: begin
               if (cnt_r <= 16'h1) begin
                  hs_start_r <= 1'b1;
                  st_r <= s_handover;
               end else cnt_r <= cnt_r - 16'h1;
            end
            s_handover: begin
               if (hs_done) st_r <= s_status;
            end
            s_status: st_r <= s_idle;
            default: st_r <= s_idle;
         endcase
      end
   end
   edge_handover u_hand (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .start(hs_start_r),
      .old_clk(old_lvl),
      .new_clk(new_lvl),
      .hold_low(hs_hold),
      .done(hs_done)
   );
   // active selection changes only at completion, old clock stays meanwhile
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         active_freq_select <= 4'h7;
         active_osc <= osc_mf_type_e;
         stat_osc_r <= 3'b010;
      end else if (st_r == s_status) begin
         active_freq_select <= pend_freq_r;
         active_osc <= pend_osc_r;
         stat_osc_r <= 3'b001 << pend_osc_r;
      end
   end
   // oscillator enables: active one plus the one starting up
   always_ff @(posedge ref_clk) begin
      if (!rstn) osc_enable <= 3'b010;
      else if (st_r == s_idle || st_r == s_status) osc_enable <= stat_osc_r;
      else osc_enable <= stat_osc_r | (3'b001 << pend_osc_r);
   end
   // source and pll decisions
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         use_internal_osc <= 1'b0;
         pll_enable <= 1'b0;
         sys_clk_hold_low <= 1'b0;
      end else begin
         use_internal_osc <= system_clock_select_r[1] ||
            (system_clock_select_r == `SCS_CONFIG && cfg_src_r == `SRC_INTERNAL_OSC_SOURCE);
         pll_enable <= (soft_pll_enable_r || cfg_pll_r) &&
            !system_clock_select_r[1];
         sys_clk_hold_low <= hs_hold;
      end
   end
   assign ctrl_rd = {soft_pll_enable_r || cfg_pll_r, internal_freq_select_r, 1'b0,
      system_clock_select_r};
   assign stat_rd = {3'h0, st_r != s_idle, pll_enable, stat_osc_r};
   // read data and waitrequest
   always_ff @(posedge ref_clk) begin
      if (!rstn) bus_rsp <= '{readdata: 32'h0, waitrequest: 1'b1};
      else begin
         bus_rsp.waitrequest <= !((bus_req.read || bus_req.write) && !ack_r);
         case (bus_req.address)
            `OFS_CTRL: bus_rsp.readdata <= {24'h0, ctrl_rd};
            `OFS_STAT: bus_rsp.readdata <= {24'h0, stat_rd};
            `OFS_CFG: bus_rsp.readdata <= {28'h0, cfg_pll_r, cfg_src_r};
            default: bus_rsp.readdata <= 32'h0;
         endcase
      end
   end
endmodule

// [osc_switch_asserts.sv]
// Purpose: bus and clock switch checks for osc_switch
// Assumes: sees only the top ports
// Notes: bound into osc_switch at the foot
`include "osc_switch_defines.svh"
module osc_switch_asserts #(
   parameter int STARTUP_CYCLES = 4 // start-up delay in ref_clk cycles
) (
   input wire logic ref_clk, // block clock
   input wire logic rstn, // sync reset, low
   input wire osc_switch_pkg::bus_req_type bus_req, // request
   input wire osc_switch_pkg::bus_rsp_type bus_rsp, // answer
   input wire logic [2:0] clock_source_config, // strap source
   input wire logic config_pll_enable, // strap pll
   input wire logic hf_clk, // high osc
   input wire logic mf_clk, // mid osc
   input wire logic lf_clk, // low osc
   input wire logic [2:0] osc_enable, // run enables
   input wire logic pll_enable, // pll on
   input wire logic use_internal_osc, // internal source
   input wire logic [3:0] active_freq_select, // live code
   input wire logic sys_clk_hold_low, // handover low
   input wire logic [1:0] active_osc // live osc
);
   import osc_switch_pkg::*;
   logic [2:0] en_q_r; // enables one cycle ago
   logic [7:0] since_en_r; // cycles since a source was started
   logic cur_clk; // level of the driving source
   assign cur_clk = active_osc == 2'h0 ? hf_clk : (active_osc == 2'h1 ? mf_clk : lf_clk);
   // time since the last oscillator start
   always_ff @(posedge ref_clk) begin
      en_q_r <= osc_enable;
      if (!rstn) since_en_r <= 8'hff;
      else if ((osc_enable & ~en_q_r) != 3'h0) since_en_r <= 8'h00;
      else if (since_en_r != 8'hff) since_en_r <= since_en_r + 8'h01;
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   AST_ANSWER: assert property ((bus_req.read || bus_req.write) && bus_rsp.waitrequest
      |=> !bus_rsp.waitrequest) else $error("no answer after request");
   AST_ONE_LOW: assert property (!bus_rsp.waitrequest |=> bus_rsp.waitrequest)
      else $error("waitrequest low too long");
   AST_UNMAPPED: assert property (bus_req.read && bus_req.address[3:2] == 2'h3
      |=> bus_rsp.readdata == 32'h0) else $error("unmapped read not zero");
   AST_INTERNAL_OSC_SOURCE: assert property (clock_source_config == `SRC_INTERNAL_OSC_SOURCE
      && $stable(clock_source_config) |-> ##3 use_internal_osc) else $error("no internal");
   AST_PLL_1X: assert property (use_internal_osc && $past(use_internal_osc)
      && clock_source_config != `SRC_INTERNAL_OSC_SOURCE |-> !pll_enable) else $error("pll on at 1x");
   AST_STARTUP: assert property ($rose(sys_clk_hold_low)
      |-> since_en_r >= STARTUP_CYCLES) else $error("start-up delay skipped");
   AST_HOLD_OLD: assert property ($rose(sys_clk_hold_low) |-> !cur_clk)
      else $error("hold before old clock low");
   AST_HOLD_END: assert property (sys_clk_hold_low |-> ##[1:40] !sys_clk_hold_low)
      else $error("hold never ends");
   AST_ACTIVE: assert property ($fell(sys_clk_hold_low) |-> ##[1:3] $changed(active_osc))
      else $error("new clock not made active");
   AST_KEEP: assert property ($changed(active_osc) |-> $past(sys_clk_hold_low, 2)
      || $past(sys_clk_hold_low, 3) || $past(sys_clk_hold_low, 4)) else $error("early swap");
endmodule
bind osc_switch osc_switch_asserts #(.STARTUP_CYCLES(STARTUP_CYCLES)) chk_u (
   .ref_clk(ref_clk), .rstn(rstn), .bus_req(bus_req), .bus_rsp(bus_rsp),
   .clock_source_config(clock_source_config), .config_pll_enable(config_pll_enable),
   .hf_clk(hf_clk), .mf_clk(mf_clk), .lf_clk(lf_clk), .osc_enable(osc_enable),
   .pll_enable(pll_enable), .use_internal_osc(use_internal_osc),
   .active_freq_select(active_freq_select), .sys_clk_hold_low(sys_clk_hold_low),
   .active_osc(active_osc));

// [osc_src_model.sv]
// Purpose: internal oscillator sources for osc_switch
// Assumes: run enables come from the block
// Notes: a stopped source sits low
module osc_src_model (
   input wire logic ref_clk, // block clock
   input wire logic [2:0] osc_enable, // run enables
   output logic hf_clk, // high osc
   output logic mf_clk, // mid osc
   output logic lf_clk // low osc
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] lvl_r = 3'h0; // source levels
   logic [3:0] cnt_r [3] = '{4'h0, 4'h0, 4'h0}; // half period counters
   assign {lf_clk, mf_clk, hf_clk} = lvl_r;
   // running sources toggle every 4, 6 or 8 cycles
   always @(posedge ref_clk) begin
      for (int i = 0; i < 3; i++) begin
         if (!osc_enable[i]) begin
            lvl_r[i] <= 1'b0;
            cnt_r[i] <= 4'h0;
         end else if (cnt_r[i] == 4'(2 * i + 3)) begin
            lvl_r[i] <= ~lvl_r[i];
            cnt_r[i] <= 4'h0;
         end else cnt_r[i] <= cnt_r[i] + 4'h1;
      end
   end
endmodule

// [osc_switch_tb.sv]
// Purpose: register and switch tests for osc_switch
// Assumes: 40 MHz ref_clk, start-up count cut to 4
// Notes: sources come from osc_src_model
`include "osc_switch_defines.svh"
module osc_switch_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import osc_switch_pkg::*;
   localparam int SU = 4; // shortened start-up count
   logic ref_clk = 1'b0;
   logic rstn = 1'b0;
   bus_req_type req = '0;
   bus_rsp_type rsp;
   logic [2:0] src = `SRC_INTERNAL_OSC_SOURCE;
   logic cpll = 1'b0;
   logic hf, mf, lf, pll, intl, hold, seen;
   logic [2:0] en;
   logic [3:0] afreq;
   logic [1:0] aosc;
   logic [7:0] q;
   int cyc;
   int err_count = 0;
   int n_checks = 0;
   // 25 ns clock
   always #12.5 ref_clk = ~ref_clk;
   osc_switch #(.STARTUP_CYCLES(SU)) dut_u (.ref_clk(ref_clk), .rstn(rstn), .bus_req(req),
      .bus_rsp(rsp), .clock_source_config(src), .config_pll_enable(cpll), .hf_clk(hf),
      .mf_clk(mf), .lf_clk(lf), .osc_enable(en), .pll_enable(pll), .use_internal_osc(intl),
      .active_freq_select(afreq), .sys_clk_hold_low(hold), .active_osc(aosc));
   osc_src_model src_u (.ref_clk(ref_clk), .osc_enable(en), .hf_clk(hf), .mf_clk(mf),
      .lf_clk(lf));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // one bus access, held until waitrequest is seen low
   task automatic xfer(input logic [3:0] a, input logic wr, input logic [7:0] d);
      req.address <= a;
      req.write <= wr;
      req.read <= !wr;
      req.writedata <= {24'h0, d};
      do @(posedge ref_clk); while (rsp.waitrequest !== 1'b0);
      q = rsp.readdata[7:0];
      req.read <= 1'b0;
      req.write <= 1'b0;
      @(posedge ref_clk);
   endtask
   task automatic wait_for(input logic [1:0] o, input logic [3:0] f);
      cyc = 0;
      seen = 1'b0;
      while (aosc !== o || afreq !== f) begin
         @(posedge ref_clk);
         cyc++;
         seen = seen | hold;
      end
   endtask
   task automatic close_out;
      if (err_count == 0 && n_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // main sequence
   initial begin
      repeat (5) @(posedge ref_clk);
      rstn <= 1'b1;
      @(posedge ref_clk);
      xfer(`OFS_CTRL, 1'b0, 8'h00);
      chk(q, `CTRL_RESET);
      chk({en, aosc, afreq, intl}, {3'h2, 2'h1, 4'h7, 1'b1});
      xfer(`OFS_STAT, 1'b1, 8'hff);
      xfer(`OFS_STAT, 1'b0, 8'h00);
      chk(q, 8'h02);
      xfer(4'hc, 1'b0, 8'h00);
      chk(q, 8'h00);
      xfer(`OFS_CFG, 1'b0, 8'h00);
      chk(q, 8'h04);
      xfer(`OFS_CTRL, 1'b1, 8'hf0);
      wait_for(2'h0, 4'he);
      chk({pll, seen, cyc > SU}, 3'b111);
      xfer(`OFS_STAT, 1'b0, 8'h00);
      chk({q[4], q[3], q[0]}, 3'b011);
      xfer(`OFS_CTRL, 1'b1, 8'he8);
      wait_for(2'h0, 4'hd);
      chk({seen, cyc < SU}, 2'b01);
      xfer(`OFS_CTRL, 1'b1, 8'h00);
      wait_for(2'h2, 4'h0);
      chk({pll, seen, cyc > SU}, 3'b011);
      rstn <= 1'b0;
      src <= 3'h0;
      cpll <= 1'b1;
      repeat (5) @(posedge ref_clk);
      rstn <= 1'b1;
      @(posedge ref_clk);
      xfer(`OFS_CTRL, 1'b0, 8'h00);
      chk({q, intl}, {8'hb8, 1'b0});
      xfer(`OFS_CTRL, 1'b1, 8'h72);
      wait_for(2'h0, 4'hf);
      xfer(`OFS_CTRL, 1'b0, 8'h00);
      chk({q, intl, pll}, {8'hfa, 2'b10});
      close_out;
   end
   // watchdog against a hang
   initial begin
      repeat (5000) @(posedge ref_clk);
      err_count++;
      close_out;
   end
endmodule
